// [shared/rtie_pkg.sv]
// constants and types shared by the rx threshold and interrupt enable block
package rtie_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register indices (byte address is four times the index)
	localparam logic [9:0] RTIE_IDX_THRESHOLD = 10'h08E;
	localparam logic [9:0] RTIE_IDX_ENABLE = 10'h090;
	localparam logic [9:0] RTIE_IDX_STATUS = 10'h092;
	localparam logic [9:0] RTIE_IDX_RXQ_CTRL = 10'h098;
	localparam logic [9:0] RTIE_IDX_CLEAR = 10'h09A;
	localparam logic [9:0] RTIE_IDX_PENDING = 10'h09C;

	localparam int RTIE_ADDR_W = 12;
	localparam logic [11:0] RTIE_ADDR_THRESHOLD = {RTIE_IDX_THRESHOLD, 2'b00};
	localparam logic [11:0] RTIE_ADDR_ENABLE = {RTIE_IDX_ENABLE, 2'b00};
	localparam logic [11:0] RTIE_ADDR_STATUS = {RTIE_IDX_STATUS, 2'b00};
	localparam logic [11:0] RTIE_ADDR_RXQ_CTRL = {RTIE_IDX_RXQ_CTRL, 2'b00};
	localparam logic [11:0] RTIE_ADDR_CLEAR = {RTIE_IDX_CLEAR, 2'b00};
	localparam logic [11:0] RTIE_ADDR_PENDING = {RTIE_IDX_PENDING, 2'b00};

	////////////////////////////////////////////////////////////////////////////////
	// bit positions shared by status, enable, clear and pending
	localparam int RTIE_BIT_LINK_CHANGE = 15;
	localparam int RTIE_BIT_TX_DONE = 14;
	localparam int RTIE_BIT_FRAME_RX = 13;
	localparam int RTIE_BIT_RX_OVERRUN = 11;
	localparam int RTIE_BIT_TX_STOPPED = 9;
	localparam int RTIE_BIT_RX_STOPPED = 8;
	localparam int RTIE_BIT_TX_SPACE = 6;
	localparam int RTIE_BIT_WAKEUP_FRAME = 5;
	localparam int RTIE_BIT_MAGIC_PACKET = 4;
	localparam int RTIE_BIT_LINKUP = 3;
	localparam int RTIE_BIT_ENERGY = 2;
	localparam int RTIE_BIT_RESERVED_RO = 1;
	localparam int RTIE_BIT_DELAYED_ENERGY = 0;

	// threshold compare enable inside the receive queue control register
	localparam int RTIE_BIT_RXQ_THR_EN = 6;

	////////////////////////////////////////////////////////////////////////////////
	// reset values and masks
	localparam logic [15:0] RTIE_THRESHOLD_RST = 16'h0000;
	localparam logic [15:0] RTIE_ENABLE_RST = 16'h0000;
	localparam logic [15:0] RTIE_STATUS_RST = 16'h0300;
	localparam logic [15:0] RTIE_RXQ_CTRL_RST = 16'h0000;
	localparam logic [15:0] RTIE_ENABLE_WMASK = 16'hFFFD;
	localparam logic [15:0] RTIE_SOURCE_MASK = 16'hEB7D;
	localparam logic [15:0] RTIE_RXQ_CTRL_MASK = 16'h0040;
	localparam logic [31:0] RTIE_RDATA_RST = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// state of the sticky status bank
	typedef struct packed {
		logic [15:0] bits;
	} rtie_sticky_state_t;

endpackage

// [hdl/rtie_sticky.sv]
// sticky interrupt status bank with write-one-to-clear
`timescale 1ns/10ps
module rtie_sticky import rtie_pkg::*; (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [15:0] set_vec,
	input wire logic [15:0] clr_vec,
	output logic [15:0] status
);

	rtie_sticky_state_t state_reg;
	rtie_sticky_state_t state_next;
	logic [15:0] bit_next;

	////////////////////////////////////////////////////////////////////////////////
	// per bit: a set in the clearing cycle wins; unused positions stay zero
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_bit
			assign bit_next[gi] = RTIE_SOURCE_MASK[gi] &
				(set_vec[gi] | (state_reg.bits[gi] & ~clr_vec[gi]));
		end
	endgenerate

	always_comb begin
		state_next = state_reg;
		state_next.bits = bit_next;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '{bits: RTIE_STATUS_RST};
		end else begin
			state_reg <= state_next;
		end
	end

	assign status = state_reg.bits;

endmodule // rtie_sticky

// [hdl/rtie_top.sv]
// rx byte-count threshold and interrupt enable logic behind an apb slave
//
// Overview of operation
// - sixteen-bit read/write receive byte threshold, counted in bytes, resets to zero.
// - with queue control bit 6 set, count going from not above to above threshold sets status bit 13, once per crossing.
// - enable bit 15 passes or blocks the link change interrupt.
// - enable bit 14 passes or blocks the transmit done interrupt.
// - enable bit 13 passes or blocks the frame received interrupt.
// - enable bit 11 passes or blocks the receive overrun interrupt.
// - enable bit 9 passes or blocks the transmit stopped interrupt.
// - enable bit 8 passes or blocks the receive stopped interrupt.
// - enable bit 6 passes or blocks the transmit space available interrupt.
// - enable bit 5 passes or blocks the wake-up frame interrupt.
// - enable bit 4 passes or blocks the magic packet interrupt.
// - enable bit 3 passes or blocks the linkup wake interrupt.
// - enable bit 2 passes or blocks the energy detect wake interrupt.
// - enable bit 0 passes or blocks the delayed energy detect interrupt.
// - delayed energy detect interrupt waits until host access is ready.
// - interrupt output is high while any status bit and its enable are set, for bit 0 only while host access is ready.
// - reads leave status untouched; writing one clears a status bit.
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
module rtie_top import rtie_pkg::*; (
	input wire logic mclk,
	input wire logic rst_n,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// event pulses from the controller core
	input wire logic evt_link_change,
	input wire logic evt_tx_done,
	input wire logic evt_frame_rx,
	input wire logic evt_rx_overrun,
	input wire logic evt_tx_stopped,
	input wire logic evt_rx_stopped,
	input wire logic evt_tx_space,
	input wire logic evt_wakeup_frame,
	input wire logic evt_magic_packet,
	input wire logic evt_linkup,
	input wire logic evt_energy,
	input wire logic evt_delayed_energy,
	// device state
	input wire logic host_access_ready,
	input wire logic [15:0] rxq_byte_count,
	// interrupt
	output logic irq
);

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [15:0] threshold;
		logic [15:0] enable;
		logic [15:0] rxq_ctrl;
		logic above_prev;
		logic [31:0] rdata;
		logic err;
	} rtie_top_state_t;

	rtie_top_state_t state_reg;
	rtie_top_state_t state_next;

	logic [15:0] status;
	logic [15:0] set_vec;
	logic [15:0] clr_vec;
	logic [15:0] irq_src;
	logic [15:0] pending;
	logic [15:0] wmask;
	logic setup_phase;
	logic access_phase;
	logic wr_access;
	logic aligned;
	logic hit_threshold;
	logic hit_enable;
	logic hit_status;
	logic hit_rxq_ctrl;
	logic hit_clear;
	logic hit_pending;
	logic mapped;
	logic above_now;
	logic thr_crossed;

	////////////////////////////////////////////////////////////////////////////////
	// apb phase and address decode

	assign setup_phase = psel & ~penable;
	assign access_phase = psel & penable;
	// zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign wr_access = access_phase & pready & pwrite;

	assign aligned = (paddr[1:0] == 2'b00);
	assign hit_threshold = aligned & (paddr == RTIE_ADDR_THRESHOLD);
	assign hit_enable = aligned & (paddr == RTIE_ADDR_ENABLE);
	assign hit_status = aligned & (paddr == RTIE_ADDR_STATUS);
	assign hit_rxq_ctrl = aligned & (paddr == RTIE_ADDR_RXQ_CTRL);
	assign hit_clear = aligned & (paddr == RTIE_ADDR_CLEAR);
	assign hit_pending = aligned & (paddr == RTIE_ADDR_PENDING);
	assign mapped = hit_threshold | hit_enable | hit_status | hit_rxq_ctrl |
		hit_clear | hit_pending;

	// byte lanes of the low halfword
	assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	////////////////////////////////////////////////////////////////////////////////
	// receive byte count threshold compare

	// edge of the compare so one crossing gives one status event
	assign above_now = state_reg.rxq_ctrl[RTIE_BIT_RXQ_THR_EN] &
		(rxq_byte_count > state_reg.threshold);
	assign thr_crossed = above_now & ~state_reg.above_prev;

	////////////////////////////////////////////////////////////////////////////////
	// event collection into the status bank

	always_comb begin
		set_vec = 16'h0000;
		set_vec[RTIE_BIT_LINK_CHANGE] = evt_link_change;
		set_vec[RTIE_BIT_TX_DONE] = evt_tx_done;
		set_vec[RTIE_BIT_FRAME_RX] = evt_frame_rx | thr_crossed;
		set_vec[RTIE_BIT_RX_OVERRUN] = evt_rx_overrun;
		set_vec[RTIE_BIT_TX_STOPPED] = evt_tx_stopped;
		set_vec[RTIE_BIT_RX_STOPPED] = evt_rx_stopped;
		set_vec[RTIE_BIT_TX_SPACE] = evt_tx_space;
		set_vec[RTIE_BIT_WAKEUP_FRAME] = evt_wakeup_frame;
		set_vec[RTIE_BIT_MAGIC_PACKET] = evt_magic_packet;
		set_vec[RTIE_BIT_LINKUP] = evt_linkup;
		set_vec[RTIE_BIT_ENERGY] = evt_energy;
		set_vec[RTIE_BIT_DELAYED_ENERGY] = evt_delayed_energy;
	end

	// write one to clear, through the status word or the clear word
	always_comb begin
		clr_vec = 16'h0000;
		if (wr_access && (hit_status || hit_clear)) begin
			clr_vec = pwdata[15:0] & wmask;
		end
	end

	rtie_sticky u_sticky (
		.mclk(mclk),
		.rst_n(rst_n),
		.set_vec(set_vec),
		.clr_vec(clr_vec),
		.status(status)
	);

	////////////////////////////////////////////////////////////////////////////////
	// enable gating onto the interrupt output

	always_comb begin
		irq_src = 16'h0000;
		irq_src[RTIE_BIT_LINK_CHANGE] = status[RTIE_BIT_LINK_CHANGE] &
			state_reg.enable[RTIE_BIT_LINK_CHANGE];
		irq_src[RTIE_BIT_TX_DONE] = status[RTIE_BIT_TX_DONE] &
			state_reg.enable[RTIE_BIT_TX_DONE];
		irq_src[RTIE_BIT_FRAME_RX] = status[RTIE_BIT_FRAME_RX] &
			state_reg.enable[RTIE_BIT_FRAME_RX];
		irq_src[RTIE_BIT_RX_OVERRUN] = status[RTIE_BIT_RX_OVERRUN] &
			state_reg.enable[RTIE_BIT_RX_OVERRUN];
		irq_src[RTIE_BIT_TX_STOPPED] = status[RTIE_BIT_TX_STOPPED] &
			state_reg.enable[RTIE_BIT_TX_STOPPED];
		irq_src[RTIE_BIT_RX_STOPPED] = status[RTIE_BIT_RX_STOPPED] &
			state_reg.enable[RTIE_BIT_RX_STOPPED];
		irq_src[RTIE_BIT_TX_SPACE] = status[RTIE_BIT_TX_SPACE] &
			state_reg.enable[RTIE_BIT_TX_SPACE];
		irq_src[RTIE_BIT_WAKEUP_FRAME] = status[RTIE_BIT_WAKEUP_FRAME] &
			state_reg.enable[RTIE_BIT_WAKEUP_FRAME];
		irq_src[RTIE_BIT_MAGIC_PACKET] = status[RTIE_BIT_MAGIC_PACKET] &
			state_reg.enable[RTIE_BIT_MAGIC_PACKET];
		irq_src[RTIE_BIT_LINKUP] = status[RTIE_BIT_LINKUP] &
			state_reg.enable[RTIE_BIT_LINKUP];
		irq_src[RTIE_BIT_ENERGY] = status[RTIE_BIT_ENERGY] &
			state_reg.enable[RTIE_BIT_ENERGY];
		// held back until the host may touch registers
		irq_src[RTIE_BIT_DELAYED_ENERGY] = status[RTIE_BIT_DELAYED_ENERGY] &
			state_reg.enable[RTIE_BIT_DELAYED_ENERGY] &
			host_access_ready;
	end

	// reserved positions are never sources, whatever their enable holds
	assign pending = irq_src & RTIE_SOURCE_MASK;
	assign irq = |pending;

	////////////////////////////////////////////////////////////////////////////////
	// register writes, read data capture

	always_comb begin
		state_next = state_reg;
		state_next.above_prev = above_now;

		if (wr_access && hit_threshold) begin
			state_next.threshold = (state_reg.threshold & ~wmask) |
				(pwdata[15:0] & wmask);
		end

		if (wr_access && hit_enable) begin
			// bit 1 has no storage and so reads back as zero
			state_next.enable = ((state_reg.enable & ~wmask) |
				(pwdata[15:0] & wmask)) & RTIE_ENABLE_WMASK;
		end

		if (wr_access && hit_rxq_ctrl) begin
			state_next.rxq_ctrl = ((state_reg.rxq_ctrl & ~wmask) |
				(pwdata[15:0] & wmask)) & RTIE_RXQ_CTRL_MASK;
		end

		// read data is latched in the setup cycle and shown in the access cycle
		if (setup_phase) begin
			state_next.err = ~mapped;
			state_next.rdata = RTIE_RDATA_RST;
			if (!pwrite) begin
				unique case (1'b1)
					hit_threshold: begin
						state_next.rdata = {16'h0000, state_reg.threshold};
					end
					hit_enable: begin
						state_next.rdata = {16'h0000, state_reg.enable};
					end
					hit_status: begin
						// reading has no side effect on the sticky bits
						state_next.rdata = {16'h0000, status};
					end
					hit_rxq_ctrl: begin
						state_next.rdata = {16'h0000, state_reg.rxq_ctrl};
					end
					hit_pending: begin
						state_next.rdata = {16'h0000, pending};
					end
					hit_clear: begin
						state_next.rdata = RTIE_RDATA_RST;
					end
					default: begin
						state_next.rdata = RTIE_RDATA_RST;
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= '{
				threshold: RTIE_THRESHOLD_RST,
				enable: RTIE_ENABLE_RST,
				rxq_ctrl: RTIE_RXQ_CTRL_RST,
				above_prev: 1'b0,
				rdata: RTIE_RDATA_RST,
				err: 1'b0
			};
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb answer

	assign prdata = state_reg.rdata;
	assign pslverr = access_phase & state_reg.err;

endmodule // rtie_top

// [dv/rtie_checker.sv]
// port assertions for the rx threshold and interrupt enable block
`timescale 1ns/10ps
module rtie_checker import rtie_pkg::*; (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic evt_link_change,
	input wire logic evt_tx_done,
	input wire logic evt_frame_rx,
	input wire logic evt_rx_overrun,
	input wire logic evt_tx_stopped,
	input wire logic evt_rx_stopped,
	input wire logic evt_tx_space,
	input wire logic evt_wakeup_frame,
	input wire logic evt_magic_packet,
	input wire logic evt_linkup,
	input wire logic evt_energy,
	input wire logic evt_delayed_energy,
	input wire logic host_access_ready,
	input wire logic [15:0] rxq_byte_count,
	input wire logic irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// shadow of the enable register, built from bus writes
	logic [15:0] en_sh;
	logic en_wr;
	assign en_wr = psel && penable && pready && pwrite && (paddr == RTIE_ADDR_ENABLE);
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			en_sh <= 16'h0000;
		end else if (en_wr) begin
			en_sh <= {pstrb[1] ? pwdata[15:8] : en_sh[15:8], pstrb[0] ? pwdata[7:0] : en_sh[7:0]};
		end
	end
	property p_gate(ev, int b);
		(ev && en_sh[b] && !en_wr) |=> irq;
	endproperty
	a_gate_link: assert property (p_gate(evt_link_change, 15)) else $error("link gate");
	a_gate_tx_done: assert property (p_gate(evt_tx_done, 14)) else $error("tx gate");
	a_gate_frame_rx: assert property (p_gate(evt_frame_rx, 13)) else $error("rx gate");
	a_gate_overrun: assert property (p_gate(evt_rx_overrun, 11)) else $error("ovr gate");
	a_gate_magic: assert property (p_gate(evt_magic_packet, 4)) else $error("magic gate");
	a_gate_tx_stop: assert property (p_gate(evt_tx_stopped, 9)) else $error("txs gate");
	a_gate_rx_stop: assert property (p_gate(evt_rx_stopped, 8)) else $error("rxs gate");
	a_gate_space: assert property (p_gate(evt_tx_space, 6)) else $error("space gate");
	a_gate_wakeup: assert property (p_gate(evt_wakeup_frame, 5)) else $error("wake gate");
	a_gate_linkup: assert property (p_gate(evt_linkup, 3)) else $error("linkup gate");
	a_gate_energy: assert property (p_gate(evt_energy, 2)) else $error("energy gate");
	a_gate_delayed: assert property ((evt_delayed_energy && en_sh[0] && !en_wr)
		|=> (irq || !host_access_ready)) else $error("delayed gate");
	a_irq_cause: assert property (irq |-> (en_sh & RTIE_SOURCE_MASK) != 16'h0000)
		else $error("irq without enable");
	a_ready_hold: assert property ((!host_access_ready && (en_sh & 16'hEB7C) == 16'h0000)
		|-> !irq) else $error("irq before ready");
	a_bit1_zero: assert property ((psel && penable && !pwrite && paddr == RTIE_ADDR_ENABLE)
		|-> !prdata[1]) else $error("enable bit 1 set");
	c_clear_irq: cover property (irq && psel && penable && pwrite);
	c_refused: cover property (pslverr);
	c_held_back: cover property (!host_access_ready && evt_delayed_energy);
endmodule // rtie_checker
////////////////////////////////////////////////////////////////////////////////
bind rtie_top rtie_checker rtie_checker_inst (.mclk(mclk), .rst_n(rst_n), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .evt_link_change(evt_link_change),
	.evt_tx_done(evt_tx_done), .evt_frame_rx(evt_frame_rx), .evt_rx_overrun(evt_rx_overrun),
	.evt_tx_stopped(evt_tx_stopped), .evt_rx_stopped(evt_rx_stopped),
	.evt_tx_space(evt_tx_space), .evt_wakeup_frame(evt_wakeup_frame),
	.evt_magic_packet(evt_magic_packet), .evt_linkup(evt_linkup), .evt_energy(evt_energy),
	.evt_delayed_energy(evt_delayed_energy), .host_access_ready(host_access_ready),
	.rxq_byte_count(rxq_byte_count), .irq(irq));

// [dv/rtie_host_model.sv]
// apb host model issuing register transfers
`timescale 1ns/10ps
module rtie_host_model (
	input wire logic mclk,
	output logic [11:0] paddr,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		paddr = 12'h000;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
	end
	// request held until pready is seen high at a rising edge
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge mclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		pstrb <= 4'hF;
		psel <= 1'b1;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) begin
			@(posedge mclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask
endmodule // rtie_host_model

// [dv/tb_top.sv]
// self-checking bench for the rx threshold and interrupt enable block
`timescale 1ns/10ps
module tb_top import rtie_pkg::*; ;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic hr = 1'b0;
	logic [15:0] ev = 16'h0000;
	logic [15:0] cnt = 16'h0000;
	logic [11:0] paddr;
	logic psel, penable, pwrite, pready, pslverr, irq, ee;
	logic [31:0] pwdata, prdata, rv;
	logic [3:0] pstrb;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	always #20 mclk = ~mclk;
	rtie_top rtie_top_inst (.mclk(mclk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .evt_link_change(ev[15]), .evt_tx_done(ev[14]),
		.evt_frame_rx(ev[13]), .evt_rx_overrun(ev[11]), .evt_tx_stopped(ev[9]),
		.evt_rx_stopped(ev[8]), .evt_tx_space(ev[6]), .evt_wakeup_frame(ev[5]),
		.evt_magic_packet(ev[4]), .evt_linkup(ev[3]), .evt_energy(ev[2]),
		.evt_delayed_energy(ev[0]), .host_access_ready(hr), .rxq_byte_count(cnt), .irq(irq));
	rtie_host_model rtie_host_model_inst (.mclk(mclk), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		rtie_host_model_inst.xfer(a, 1'b1, {16'h0000, d}, rv, ee);
		#1;
	endtask
	task automatic rd(input logic [11:0] a);
		rtie_host_model_inst.xfer(a, 1'b0, 32'h0000_0000, rv, ee);
	endtask
	task automatic pulse(input logic [15:0] m);
		@(posedge mclk);
		ev <= m;
		@(posedge mclk);
		ev <= 16'h0000;
		#1;
	endtask
	task automatic setc(input logic [15:0] v);
		@(posedge mclk);
		cnt <= v;
		@(posedge mclk);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd(RTIE_ADDR_THRESHOLD);
		check(rv, 32'h0000_0000);
		rd(RTIE_ADDR_STATUS);
		check(rv, 32'h0000_0300);
		wr(RTIE_ADDR_THRESHOLD, 16'hFFFF);
		rd(RTIE_ADDR_THRESHOLD);
		check(rv, 32'h0000_FFFF);
		wr(RTIE_ADDR_ENABLE, 16'hFFFF);
		rd(RTIE_ADDR_ENABLE);
		check(rv, 32'h0000_FFFD);
		rd(12'h004);
		check({31'h0, ee}, 32'h1);
		check({31'h0, irq}, 32'h1);
		wr(RTIE_ADDR_STATUS, 16'hFFFF);
		check({31'h0, irq}, 32'h0);
	endtask
	task automatic t_gates();
		logic [15:0] m;
		@(posedge mclk);
		hr <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			m = 16'h0001 << i;
			if ((m & RTIE_SOURCE_MASK) != 16'h0000) begin
				wr(RTIE_ADDR_ENABLE, m);
				pulse(m);
				check({31'h0, irq}, 32'h1);
				wr(RTIE_ADDR_CLEAR, m);
				check({31'h0, irq}, 32'h0);
				wr(RTIE_ADDR_ENABLE, ~m);
				pulse(m);
				check({31'h0, irq}, 32'h0);
				wr(RTIE_ADDR_STATUS, m);
			end
		end
	endtask
	task automatic t_sticky();
		wr(RTIE_ADDR_ENABLE, 16'h1482);
		pulse(16'h4000);
		check({31'h0, irq}, 32'h0);
		rd(RTIE_ADDR_STATUS);
		rd(RTIE_ADDR_STATUS);
		check(rv, 32'h0000_4000);
		wr(RTIE_ADDR_STATUS, 16'hBFFF);
		rd(RTIE_ADDR_STATUS);
		check(rv, 32'h0000_4000);
		wr(RTIE_ADDR_STATUS, 16'h4000);
		rd(RTIE_ADDR_STATUS);
		check(rv, 32'h0000_0000);
	endtask
	task automatic t_delay();
		@(posedge mclk);
		hr <= 1'b0;
		wr(RTIE_ADDR_ENABLE, 16'h0001);
		pulse(16'h0001);
		check({31'h0, irq}, 32'h0);
		rd(RTIE_ADDR_PENDING);
		check(rv, 32'h0000_0000);
		@(posedge mclk);
		hr <= 1'b1;
		#1;
		check({31'h0, irq}, 32'h1);
		rd(RTIE_ADDR_PENDING);
		check(rv, 32'h0000_0001);
		rd(RTIE_ADDR_CLEAR);
		check(rv, 32'h0000_0000);
		wr(RTIE_ADDR_CLEAR, 16'h0001);
	endtask
	task automatic t_thr();
		wr(RTIE_ADDR_THRESHOLD, 16'h0064);
		wr(RTIE_ADDR_RXQ_CTRL, 16'h0040);
		wr(RTIE_ADDR_ENABLE, 16'h2000);
		setc(16'h0064);
		check({31'h0, irq}, 32'h0);
		setc(16'h0065);
		check({31'h0, irq}, 32'h1);
		wr(RTIE_ADDR_CLEAR, 16'h2000);
		setc(16'h0066);
		check({31'h0, irq}, 32'h0);
		wr(RTIE_ADDR_RXQ_CTRL, 16'h0000);
		setc(16'h0000);
		setc(16'h0065);
		check({31'h0, irq}, 32'h0);
		// compare switched on while already above counts as a crossing
		wr(RTIE_ADDR_RXQ_CTRL, 16'hFFFF);
		setc(16'h0065);
		check({31'h0, irq}, 32'h1);
		rd(RTIE_ADDR_RXQ_CTRL);
		check(rv, 32'h0000_0040);
		wr(RTIE_ADDR_CLEAR, 16'h2000);
	endtask
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		t_regs();
		t_gates();
		t_sticky();
		t_delay();
		t_thr();
		give_verdict();
	end
endmodule // tb_top
